/* sre_pkg.sv */
// Purpose: shared constants and types for the secded memory block
// Assumes: one clock domain, word-indexed avalon register map
// Notes:   check-bit matrix is built from the position function below
package sre_pkg;
    // array geometry
    localparam int DEPTH = 512;
    localparam int AW    = 9;
    localparam int DW    = 64;
    localparam int CW    = 8;
    localparam int WW    = 72;
    // injected bit positions in the data word
    localparam int INJ_BIT_A = 30;
    localparam int INJ_BIT_B = 62;
    // register word indices
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_CNT  = 2'h1;
    localparam logic [1:0] REG_LAST = 2'h2;
    // control field positions and reset value
    localparam int CTRL_ENC   = 0;
    localparam int CTRL_DEC   = 1;
    localparam int CTRL_OREG  = 2;
    localparam int CTRL_PIPE  = 3;
    localparam int CTRL_WM_LO = 4;
    localparam int CTRL_WM_HI = 5;
    localparam logic [7:0] CTRL_RST = 8'h03;
    // last-error register fields
    localparam int LAST_DBL = 16;

    typedef enum logic [1:0] {SRE_WM_RBW, SRE_WM_WBR, SRE_WM_HOW} sre_wmode_e;
    typedef enum logic {SRE_IDLE, SRE_ACK} sre_bus_e;
    typedef logic [6:0] sre_pos_t;

    // hamming position (3..71, powers of two skipped) of data bit idx
    function automatic sre_pos_t sre_data_pos(input int idx);
        int n;
        int p;
        n = 0;
        sre_data_pos = 7'h00;
        for (p = 3; p < WW; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (n == idx) sre_data_pos = sre_pos_t'(p);
                n++;
            end
        end
    endfunction : sre_data_pos
endpackage : sre_pkg

/* sre_codec_if.sv */
// Purpose: carrier between the memory top and its codec
// Assumes: purely combinational use
// Notes:   encode and decode paths are independent
`timescale 1ns/1ps
interface sre_codec_if;
    logic [63:0] enc_data;
    logic [7:0]  enc_check;
    logic [71:0] dec_word;
    logic [63:0] dec_data;
    logic        dec_sbe;
    logic        dec_dbe;
    modport codec (input enc_data, dec_word, output enc_check, dec_data, dec_sbe, dec_dbe);
    modport user  (output enc_data, dec_word, input enc_check, dec_data, dec_sbe, dec_dbe);
endinterface : sre_codec_if

/* sre_codec.sv */
// Purpose: extended hamming secded encoder and decoder
// Assumes: word layout {check[7:0], data[63:0]}
// Notes:   check[6:0] are position parities, check[7] overall parity
`timescale 1ns/1ps
module sre_codec
    import sre_pkg::*;
(
    sre_codec_if.codec cif
);
    // position parity over the 64 data bits
    function automatic logic [6:0] sre_psum(input logic [63:0] d);
        sre_pos_t p;
        sre_psum = 7'h00;
        for (int i = 0; i < DW; i++) begin
            p = sre_data_pos(i);
            if (d[i]) sre_psum = sre_psum ^ p;
        end
    endfunction : sre_psum

    always_comb begin
        cif.enc_check[6:0] = sre_psum(cif.enc_data);
        cif.enc_check[7]   = ^{cif.enc_data, cif.enc_check[6:0]};
    end

    always_comb begin
        logic [6:0] syn;
        logic       ovr;
        syn = sre_psum(cif.dec_word[63:0]) ^ cif.dec_word[70:64];
        ovr = ^cif.dec_word;
        cif.dec_data = cif.dec_word[63:0];
        for (int i = 0; i < DW; i++) begin
            if (ovr && syn == sre_data_pos(i)) cif.dec_data[i] = ~cif.dec_word[i];
        end
        cif.dec_sbe = ovr;
        cif.dec_dbe = !ovr && (syn != 7'h00);
    end
endmodule : sre_codec

/* sre_top.sv */
// Purpose: 512 x 64 two-port memory with built-in secded protection
// Assumes: write and read ports both on sys_clk, avalon slave for config
// Notes:   decoder pipeline register carries no reset by design
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Function
// - array is 512 words of 64 data bits plus 8 check bits
// - each write encodes 8 check bits from write data; standard and encode-only modes store them
// - reads correct single-bit errors and detect double-bit errors
// - computed check bits show on ecc_check_bits one sys_clk edge later, through a register stage
// - decoder uses all 72 bits, flags give none, corrected or double
// - correction appears only on output, stored word stays as it was
// - output_reg_select adds one register stage to data and both flags
// - memory variant injects errors and echoes the read address
// - fifo variant: standard mode only, injection kept, no address echo
// - standard mode stores generated code and ignores write_check_in
// - decode-only stores user check bits, reads still decode and correct
// - encode-only stores generated code, reads return raw bits undecoded
// - one dedicated write port and one dedicated read port
// - read_data_out holds until the next enabled read
// - read-before-write and write-before-read modes supported; hold-on-write reads as read-before-write
// - decode_pipe_enable splits decoder, adding one cycle read latency
// - pipeline register gated by decode_pipe_ce, no reset, ignores clears
// - fifo variant drives the pipeline enable itself
// - injectors flip data bit 30, or bits 30 and 62 for double
// - encode-only reads never raise either error flag
// - read_addr_echo gives the address of the word on read_data_out
module sre_top
    import sre_pkg::*;
#(
    parameter bit FIFO_VARIANT = 1'b0
)(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // avalon slave
    input  wire logic [1:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // write port
    input  wire logic              write_en,
    input  wire logic [AW-1:0]     write_addr,
    input  wire logic [DW-1:0]     write_data_in,
    input  wire logic [CW-1:0]     write_check_in,
    input  wire logic              inject_single_err,
    input  wire logic              inject_double_err,
    output logic      [CW-1:0]     ecc_check_bits,
    // read port
    input  wire logic              read_en,
    input  wire logic [AW-1:0]     read_addr,
    input  wire logic              decode_pipe_ce,
    input  wire logic              latch_clear,
    input  wire logic              outreg_clear,
    output logic      [DW-1:0]     read_data_out,
    output logic      [CW-1:0]     read_check_out,
    output logic                   single_err_flag,
    output logic                   double_err_flag,
    output logic      [AW-1:0]     read_addr_echo
);
    import sre_pkg::*;

    sre_codec_if cif ();

    logic [WW-1:0] mem_r [DEPTH];
    logic [7:0]    ctrl_r;
    sre_bus_e      bus_st_r;
    logic          wait_r;
    logic [31:0]   rdata_r;
    logic [31:0]   rd_mux;
    logic [15:0]   sbe_cnt_r;
    logic [15:0]   dbe_cnt_r;
    logic [AW-1:0] last_addr_r;
    logic          last_dbl_r;
    logic          enc_en;
    logic          dec_en;
    logic          oreg_en;
    logic          pipe_en;
    logic          pipe_ce;
    sre_wmode_e    wmode;
    logic [DW-1:0] wr_data;
    logic [WW-1:0] wr_word;
    logic [WW-1:0] raw;
    logic [WW-1:0] pipe_raw_r;
    logic [AW-1:0] pipe_addr_r;
    logic          rd_d1_r;
    logic          ld;
    logic [WW-1:0] dec_in;
    logic [AW-1:0] dec_addr;
    logic [DW-1:0] res_data;
    logic          res_sbe;
    logic          res_dbe;
    logic [DW-1:0] lat_data_r;
    logic [CW-1:0] lat_chk_r;
    logic          lat_sbe_r;
    logic          lat_dbe_r;
    logic [AW-1:0] lat_addr_r;
    logic          lat_vld_r;
    logic          cnt_clr;
    logic [CW-1:0] chk_r;

    sre_codec u_codec (
        .cif (cif.codec)
    );

    // effective mode bits
    // fifo forces standard
    assign enc_en  = FIFO_VARIANT | ctrl_r[CTRL_ENC];
    assign dec_en  = FIFO_VARIANT | ctrl_r[CTRL_DEC];
    assign oreg_en = ctrl_r[CTRL_OREG];
    assign pipe_en = ctrl_r[CTRL_PIPE];
    assign wmode   = sre_wmode_e'(ctrl_r[CTRL_WM_HI:CTRL_WM_LO]);
    assign pipe_ce = FIFO_VARIANT ? read_en : decode_pipe_ce;

    // avalon handshake, one wait cycle per access
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_st_r <= SRE_IDLE;
            wait_r   <= 1'b1;
            rdata_r  <= 32'h0000_0000;
        end else begin
            unique case (bus_st_r)
                SRE_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_st_r <= SRE_ACK;
                        wait_r   <= 1'b0;
                        rdata_r  <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                SRE_ACK: begin
                    bus_st_r <= SRE_IDLE;
                    wait_r   <= 1'b1;
                end
            endcase
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

    // register read mux, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            REG_CTRL: rd_mux[7:0] = ctrl_r;
            REG_CNT:  rd_mux = {dbe_cnt_r, sbe_cnt_r};
            REG_LAST: begin
                rd_mux[AW-1:0]     = last_addr_r;
                rd_mux[LAST_DBL]   = last_dbl_r;
            end
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // control register write
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= CTRL_RST;
        end else if (avs_write && bus_st_r == SRE_ACK && avs_address == REG_CTRL
                     && avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[7:0];
        end
    end

    assign cnt_clr = avs_write && bus_st_r == SRE_ACK && avs_address == REG_CNT;

    // error counters, event beats clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sbe_cnt_r <= 16'h0000;
            dbe_cnt_r <= 16'h0000;
        end else begin
            if (ld && res_sbe)
                sbe_cnt_r <= cnt_clr ? 16'h0001 :
                             (sbe_cnt_r == 16'hffff ? sbe_cnt_r : sbe_cnt_r + 16'h0001);
            else if (cnt_clr)
                sbe_cnt_r <= 16'h0000;
            if (ld && res_dbe)
                dbe_cnt_r <= cnt_clr ? 16'h0001 :
                             (dbe_cnt_r == 16'hffff ? dbe_cnt_r : dbe_cnt_r + 16'h0001);
            else if (cnt_clr)
                dbe_cnt_r <= 16'h0000;
        end
    end

    // address of most recent flagged word
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_addr_r <= '0;
            last_dbl_r  <= 1'b0;
        end else if (ld && (res_sbe || res_dbe)) begin
            last_addr_r <= dec_addr;
            last_dbl_r  <= res_dbe;
        end
    end

    always_comb begin
        wr_data = write_data_in;
        if ((enc_en || dec_en) && (inject_single_err || inject_double_err))
            wr_data[INJ_BIT_A] = ~write_data_in[INJ_BIT_A];
        if ((enc_en || dec_en) && inject_double_err)
            wr_data[INJ_BIT_B] = ~write_data_in[INJ_BIT_B];
    end

    assign cif.enc_data = write_data_in;
    assign wr_word      = {enc_en ? cif.enc_check : write_check_in, wr_data};

    always_ff @(posedge sys_clk) begin
        if (write_en)
            mem_r[write_addr] <= wr_word;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            chk_r <= '0;
        else
            chk_r <= cif.enc_check;
    end

    assign ecc_check_bits = chk_r;

    always_comb begin
        raw = mem_r[read_addr];
        if (wmode == SRE_WM_WBR && write_en && write_addr == read_addr)
            raw = wr_word;
    end

    always_ff @(posedge sys_clk) begin
        if (pipe_ce) begin
            pipe_raw_r  <= raw;
            pipe_addr_r <= read_addr;
        end
    end

    // delayed read strobe for pipelined load
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            rd_d1_r <= 1'b0;
        else
            rd_d1_r <= read_en;
    end

    assign ld           = pipe_en ? rd_d1_r : read_en;
    assign dec_in       = pipe_en ? pipe_raw_r : raw;
    assign dec_addr     = pipe_en ? pipe_addr_r : read_addr;
    assign cif.dec_word = dec_in;

    always_comb begin
        if (dec_en) begin
            res_data = cif.dec_data;
            res_sbe  = cif.dec_sbe;
            res_dbe  = cif.dec_dbe;
        end else begin
            res_data = dec_in[DW-1:0];
            res_sbe  = 1'b0;
            res_dbe  = 1'b0;
        end
    end

    // latch stage, cleared by latch_clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_data_r <= '0;
            lat_chk_r  <= '0;
            lat_sbe_r  <= 1'b0;
            lat_dbe_r  <= 1'b0;
            lat_addr_r <= '0;
        end else if (latch_clear) begin
            lat_data_r <= '0;
            lat_chk_r  <= '0;
            lat_sbe_r  <= 1'b0;
            lat_dbe_r  <= 1'b0;
        end else if (ld) begin
            lat_data_r <= res_data;
            lat_chk_r  <= dec_in[WW-1:DW];
            lat_sbe_r  <= res_sbe;
            lat_dbe_r  <= res_dbe;
            lat_addr_r <= dec_addr;
        end
    end

    // load strobe for the output register stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            lat_vld_r <= 1'b0;
        else
            lat_vld_r <= ld;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_data_out   <= '0;
            read_check_out  <= '0;
            single_err_flag <= 1'b0;
            double_err_flag <= 1'b0;
            read_addr_echo  <= '0;
        end else if (oreg_en) begin
            if (outreg_clear) begin
                read_data_out   <= '0;
                read_check_out  <= '0;
                single_err_flag <= 1'b0;
                double_err_flag <= 1'b0;
            end else if (lat_vld_r) begin
                read_data_out   <= lat_data_r;
                read_check_out  <= lat_chk_r;
                single_err_flag <= lat_sbe_r;
                double_err_flag <= lat_dbe_r;
                read_addr_echo  <= FIFO_VARIANT ? '0 : lat_addr_r;
            end
        end else if (latch_clear) begin
            read_data_out   <= '0;
            read_check_out  <= '0;
            single_err_flag <= 1'b0;
            double_err_flag <= 1'b0;
        end else if (ld) begin
            read_data_out   <= res_data;
            read_check_out  <= dec_in[WW-1:DW];
            single_err_flag <= res_sbe;
            double_err_flag <= res_dbe;
            read_addr_echo  <= FIFO_VARIANT ? '0 : dec_addr;
        end
    end
endmodule : sre_top

/* sre_top_asserts.sv */
// Purpose: port-level checks for sre_top
// Assumes: one clock; ctrl is shadowed from accepted bus writes
// Notes:   latency checks assume ctrl steady around reads
`timescale 1ns/1ps
module sre_top_asserts (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [1:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [63:0] write_data_in,
    input wire logic [7:0]  ecc_check_bits,
    input wire logic        read_en,
    input wire logic [8:0]  read_addr,
    input wire logic        latch_clear,
    input wire logic [63:0] read_data_out,
    input wire logic        single_err_flag,
    input wire logic        double_err_flag,
    input wire logic [8:0]  read_addr_echo
);
    logic [5:0] ctl_r;

    // ctrl shadow, loaded on accepted writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_r <= 6'h03;
        end else if (avs_write && !avs_waitrequest && avs_address == 2'h0 && avs_byteenable[0]) begin
            ctl_r <= avs_writedata[5:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // read taken with one or two extra stages
    sequence s_one_stage;
        read_en && (ctl_r[3:2] == 2'h1 || ctl_r[3:2] == 2'h2);
    endsequence
    sequence s_two_stage;
        read_en && ctl_r[3:2] == 2'h3;
    endsequence

    a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low over one cycle");
    a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    a_no_request: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_zero: assert property (avs_read && avs_address == 2'h3 && avs_waitrequest |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_check_follow: assert property ($stable(write_data_in) |=> $stable(ecc_check_bits))
        else $error("check bits moved with steady data");
    a_echo_addr: assert property (read_en && ctl_r[3:2] == 2'h0 |=> read_addr_echo == $past(read_addr))
        else $error("echo address wrong");
    a_hold_idle: assert property (!read_en && ctl_r[3:2] == 2'h0 && !latch_clear |=> $stable(read_data_out))
        else $error("read data moved without read");
    a_one_stage: assert property (s_one_stage |=> ##1 read_addr_echo == $past(read_addr, 2))
        else $error("one-stage latency wrong");
    a_two_stage: assert property (s_two_stage |=> ##2 read_addr_echo == $past(read_addr, 3))
        else $error("two-stage latency wrong");
    a_flags_excl: assert property (!(single_err_flag && double_err_flag))
        else $error("both error flags high");
    a_enc_quiet: assert property (read_en && ctl_r[1:0] == 2'h1 && ctl_r[3:2] == 2'h0
                                  |=> !single_err_flag && !double_err_flag)
        else $error("flag raised in encode-only");
endmodule : sre_top_asserts

bind sre_top sre_top_asserts u_chk (.*);

/* sre_fab_model.sv */
// Purpose: user fabric model on the write and read ports
// Assumes: callers enter tasks just after a rising edge
// Notes:   one operation at a time, so no same-address collision
`timescale 1ns/1ps
module sre_fab_model (
    input  wire logic  sys_clk,
    output logic       write_en,
    output logic [8:0] write_addr,
    output logic [63:0] write_data_in,
    output logic [7:0] write_check_in,
    output logic       inject_single_err,
    output logic       inject_double_err,
    output logic       read_en,
    output logic [8:0] read_addr,
    output logic       decode_pipe_ce
);
    // idle port values
    initial begin
        {write_en, write_addr, write_data_in, write_check_in} = '0;
        {inject_single_err, inject_double_err, read_en, read_addr, decode_pipe_ce} = '0;
    end

    task wr(input logic [8:0] a, input logic [63:0] d, input logic [7:0] c, input logic [1:0] inj);
        write_en <= 1'b1;
        write_addr <= a;
        write_data_in <= d;
        write_check_in <= c;
        {inject_double_err, inject_single_err} <= inj;
        @(posedge sys_clk);
        write_en <= 1'b0;
        {inject_double_err, inject_single_err} <= 2'h0;
        @(posedge sys_clk);
    endtask : wr

    task rd(input logic [8:0] a);
        read_en <= 1'b1;
        decode_pipe_ce <= 1'b1;
        read_addr <= a;
        @(posedge sys_clk);
        read_en <= 1'b0;
        decode_pipe_ce <= 1'b0;
    endtask : rd
endmodule : sre_fab_model

/* tb_top.sv */
// Purpose: self-checking bench for sre_top
// Assumes: fabric model drives write and read ports
// Notes:   expected codes come from an independent encoder
`timescale 1ns/1ps
module tb_top;
    import sre_pkg::*;
    logic        sys_clk = 1'b0, arst_n = 1'b0;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        avs_waitrequest, write_en, inject_single_err, inject_double_err;
    logic        read_en, decode_pipe_ce, single_err_flag, double_err_flag;
    logic        latch_clear = 1'b0, outreg_clear = 1'b0;
    logic [8:0]  write_addr, read_addr, read_addr_echo;
    logic [63:0] write_data_in, read_data_out, d = 64'h0123456789abcdef;
    logic [7:0]  write_check_in, ecc_check_bits, read_check_out;
    int          n_errors = 0, tests_run = 0, cyc = 0;

    sre_fab_model fab (.*);
    sre_top dut (.*);

    always #5 sys_clk = ~sys_clk;

    // reference encoder: xor of positions, then overall parity
    function automatic logic [7:0] enc(input logic [63:0] v);
        int p, n;
        logic [7:0] c;
        c = 8'h00;
        n = 0;
        for (p = 3; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (v[n]) c[6:0] ^= p[6:0];
                n++;
            end
        end
        c[7] = ^{c[6:0], v};
        return c;
    endfunction : enc

    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk

    // one avalon access, held until waitrequest is seen low at a rising edge
    task av(input logic w, input logic [1:0] a, input logic [31:0] wd, output logic [31:0] r);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : av

    // read one word and judge it after lat edges
    task rd_chk(input logic [8:0] a, input logic [63:0] ed, input logic [1:0] ef, input int lat);
        fab.rd(a);
        repeat (lat - 1) begin
            @(negedge sys_clk);
            chk(read_addr_echo !== a, "output too early");
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        chk(read_addr_echo === a, "echo address");
        chk({double_err_flag, single_err_flag} === ef, "error flags");
        if (ef != 2'b10) chk(read_data_out === ed, "read data");
        @(posedge sys_clk);
    endtask : rd_chk

    task t_regs;
        logic [1:0] m;
        av(1'b0, REG_CTRL, 32'h0, q);
        chk(q[7:0] === CTRL_RST, "ctrl reset");
        for (m = 0; m < 3; m++) begin
            av(1'b1, REG_CTRL, {26'h0, m, 4'h3}, q);
            av(1'b0, REG_CTRL, 32'h0, q);
            chk(q[5:0] === {m, 4'h3}, "write mode field");
        end
        av(1'b1, 2'h3, 32'hffffffff, q);
        av(1'b0, 2'h3, 32'h0, q);
        chk(q === 32'h0, "unmapped read");
        av(1'b1, REG_CTRL, 32'h3, q);
    endtask : t_regs

    task t_std;
        fab.wr(9'h010, d, 8'h5a, 2'b00);
        chk(ecc_check_bits === enc(d), "encoder output");
        fab.wr(9'h011, ~d, 8'ha5, 2'b01);
        fab.wr(9'h012, d, 8'h00, 2'b10);
        fab.wr(9'h013, d, 8'h00, 2'b11);
        rd_chk(9'h010, d, 2'b00, 1);
        chk(read_check_out === enc(d), "stored code");
        rd_chk(9'h011, ~d, 2'b01, 1);
        rd_chk(9'h012, d, 2'b10, 1);
        rd_chk(9'h013, d, 2'b10, 1);
        rd_chk(9'h011, ~d, 2'b01, 1);
        fab.wr(9'h014, ~d, 8'h00, 2'b00);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(read_data_out === ~d && single_err_flag === 1'b1, "output hold");
        @(posedge sys_clk);
        // two single and two double reads above
        av(1'b0, REG_CNT, 32'h0, q);
        chk(q === 32'h0002_0002, "error counts");
        av(1'b0, REG_LAST, 32'h0, q);
        chk(q === 32'h0000_0011, "last flagged address");
        av(1'b1, REG_CNT, 32'h0, q);
        av(1'b0, REG_CNT, 32'h0, q);
        chk(q === 32'h0, "count clear");
    endtask : t_std

    task t_modes;
        av(1'b1, REG_CTRL, 32'h2, q);
        fab.wr(9'h020, d ^ 64'h20, enc(d), 2'b00);
        fab.wr(9'h021, d ^ 64'h220, enc(d), 2'b00);
        rd_chk(9'h020, d, 2'b01, 1);
        rd_chk(9'h021, d, 2'b10, 1);
        av(1'b1, REG_CTRL, 32'h1, q);
        fab.wr(9'h030, d, 8'h00, 2'b01);
        rd_chk(9'h030, d ^ 64'h40000000, 2'b00, 1);
        chk(read_check_out === enc(d), "raw code");
    endtask : t_modes

    task t_lat;
        int i;
        for (i = 0; i < 4; i++) begin
            av(1'b1, REG_CTRL, {28'h0, i[1:0], 2'h3}, q);
            rd_chk(9'h010, d, 2'b00, 1 + i[0] + i[1]);
            rd_chk(9'h011, ~d, 2'b01, 1 + i[0] + i[1]);
        end
    endtask : t_lat

    // synchronous clears of the latch stage and the output stage
    task t_clr;
        av(1'b1, REG_CTRL, 32'h3, q);
        rd_chk(9'h011, ~d, 2'b01, 1);
        latch_clear <= 1'b1;
        @(posedge sys_clk);
        latch_clear <= 1'b0;
        @(negedge sys_clk);
        chk(read_data_out === 64'h0 && single_err_flag === 1'b0, "latch clear");
        @(posedge sys_clk);
        av(1'b1, REG_CTRL, 32'h7, q);
        rd_chk(9'h010, d, 2'b00, 2);
        outreg_clear <= 1'b1;
        @(posedge sys_clk);
        outreg_clear <= 1'b0;
        @(negedge sys_clk);
        chk(read_data_out === 64'h0, "output clear");
        @(posedge sys_clk);
        av(1'b1, REG_CTRL, 32'h3, q);
    endtask : t_clr

    task finish_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_std();
        t_modes();
        t_lat();
        t_clr();
        finish_test();
    end
endmodule : tb_top
